// >>> core/tgc_pkg.sv
// Package for the timer gate control block: register map, fields, resets.
package tgc_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [3:0] TGC_ADDR_GATE = 4'h0;
  localparam logic [3:0] TGC_ADDR_CTRL = 4'h1;
  localparam logic [3:0] TGC_ADDR_IRQ_STAT = 4'h2;
  localparam logic [3:0] TGC_ADDR_IRQ_MASK = 4'h3;
  localparam logic [3:0] TGC_ADDR_COUNT_LO = 4'h4;
  localparam logic [3:0] TGC_ADDR_COUNT_HI = 4'h5;
  // ----------------------------------------
  // Gate control register fields
  // ----------------------------------------
  localparam int TGC_BIT_GE = 7;
  localparam int TGC_BIT_POL = 6;
  localparam int TGC_BIT_TGL = 5;
  localparam int TGC_BIT_SPM = 4;
  localparam int TGC_BIT_ACQ = 3;
  localparam int TGC_BIT_VAL = 2;
  localparam int TGC_BIT_SRC_HI = 1;
  localparam int TGC_BIT_SRC_LO = 0;
  // Control register: counter-on bit
  localparam int TGC_BIT_ON = 0;
  // Interrupt bits: gate period done, counter overflow
  localparam int TGC_IRQ_GATE = 0;
  localparam int TGC_IRQ_OVF = 1;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] TGC_RST_GATE = 8'h00;
  localparam logic [7:0] TGC_RST_CTRL = 8'h00;
  localparam logic [1:0] TGC_RST_IRQ = 2'h0;
  localparam logic [15:0] TGC_RST_COUNT = 16'h0000;
  // Single-pulse sequencer states
  typedef enum logic [1:0] {SP_IDLE, SP_WAIT, SP_COUNT} tgc_sp_t;
endpackage : tgc_pkg

// >>> core/tgc_edge.sv
// Registered edge detector used on the gate paths.
`timescale 1ns/1ps
`default_nettype none
module tgc_edge (
  input wire logic clk, // Clock
  input wire logic rst, // Synchronous reset
  input wire logic sig, // Level to watch
  output logic rise, // High in the same cycle as a rising edge
  output logic fall // High in the same cycle as a falling edge
);
  logic prev_q;
  // ----------------------------------------
  // Previous value and edge flags
  // ----------------------------------------
  // Previous sample; reset loads the live level so no false edge follows reset
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q <= sig;
    end else begin
      prev_q <= sig;
    end
  end
  assign rise = sig & ~prev_q;
  assign fall = ~sig & prev_q;
endmodule : tgc_edge
`default_nettype wire

// >>> core/tgc_gate_ctrl.sv
// Gate control of a 16-bit timer: gate modes, status bits, count and interrupts.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Polarity 1 counts while gate high; polarity 0 counts while gate low.
// - Toggle select 1 enables toggle mode; 0 holds toggle flip-flop cleared.
// - In toggle mode the gate flip-flop inverts on each gate rising edge.
// - Single-pulse select 1 lets the single-pulse logic control the gate.
// - Acquire flag 1 means armed, waiting for the starting gate edge.
// - Hardware clears acquire flag when acquisition completes; software sets it.
// - Gate level status shows the present gate, regardless of gate enable.
module tgc_gate_ctrl
  import tgc_pkg::*;
(
  input wire logic clk, // 25 MHz clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [3:0] addr, // Register address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [7:0] rdata, // Read data, cycle after rd
  input wire logic [3:0] gate_src, // Candidate gate sources
  input wire logic count_tick, // Counting clock enable pulse
  output logic count_en, // Counter allowed to advance
  output logic [15:0] count, // Count register pair
  output logic irq // Level interrupt
);
  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic gate_enable_bit_q;
  logic gate_polarity_q;
  logic gate_toggle_select_q;
  logic single_pulse_select_q;
  logic pulse_acquire_flag_q;
  logic [1:0] gate_source_select_q;
  logic counter_on_bit_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic [15:0] count_q;
  logic toggle_ff_q;
  logic gate_level_status_q;
  tgc_sp_t sp_q;
  logic [7:0] rdata_q;
  logic count_en_q;
  logic irq_q;

  // ----------------------------------------
  // Gate path decode
  // ----------------------------------------
  logic gate_raw;
  logic gate_pol;
  logic pol_rise;
  logic pol_fall;
  logic gate_tgl;
  logic tgl_rise;
  logic tgl_fall;
  logic gate_func;
  logic sp_window;
  logic gate_ok;
  logic counting_gate_enable;
  logic sp_done;
  logic cnt_step;
  logic cnt_ovf;

  // Selected source; encodings of the select field are left generic
  // Sources must already be synchronous: no synchroniser sits on this path
  assign gate_raw = gate_src[gate_source_select_q];
  assign gate_pol = gate_polarity_q ? gate_raw : ~gate_raw;

  tgc_edge u_pol_edge (
    .clk(clk),
    .rst(rst),
    .sig(gate_pol),
    .rise(pol_rise),
    .fall(pol_fall)
  );

  // toggle mode selects the flip-flop output
  assign gate_tgl = gate_toggle_select_q ? toggle_ff_q : gate_pol;

  tgc_edge u_tgl_edge (
    .clk(clk),
    .rst(rst),
    .sig(gate_tgl),
    .rise(tgl_rise),
    .fall(tgl_fall)
  );

  // single-pulse window gates the counter when selected
  assign sp_window = (sp_q == SP_COUNT) & gate_tgl;
  assign gate_func = single_pulse_select_q ? sp_window : gate_tgl;
  // Single pulse ends on the falling edge of the qualified gate
  assign sp_done = single_pulse_select_q & (sp_q == SP_COUNT) & tgl_fall;
  // gate enable matters only while the counter is on
  assign counting_gate_enable = counter_on_bit_q & gate_enable_bit_q;
  assign gate_ok = counting_gate_enable ? gate_func : 1'b1;
  assign cnt_step = counter_on_bit_q & gate_ok & count_tick;
  assign cnt_ovf = cnt_step & (count_q == 16'hFFFF);

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  logic wr_gate;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  logic wr_lo;
  logic wr_hi;
  logic [7:0] gate_rd;
  logic [7:0] rd_mux;
  logic [1:0] irq_set;
  logic [7:0] ctrl_rd;
  logic [7:0] stat_rd;
  logic [7:0] mask_rd;
  logic [7:0] rdata_d;

  assign wr_gate = wr & (addr == TGC_ADDR_GATE);
  assign wr_ctrl = wr & (addr == TGC_ADDR_CTRL);
  assign wr_stat = wr & (addr == TGC_ADDR_IRQ_STAT);
  assign wr_mask = wr & (addr == TGC_ADDR_IRQ_MASK);
  assign wr_lo = wr & (addr == TGC_ADDR_COUNT_LO);
  assign wr_hi = wr & (addr == TGC_ADDR_COUNT_HI);
  assign gate_rd = {gate_enable_bit_q, gate_polarity_q, gate_toggle_select_q,
                    single_pulse_select_q, pulse_acquire_flag_q,
                    gate_level_status_q, gate_source_select_q};
  // Narrow registers padded to a byte; unused bits read as zero
  assign ctrl_rd = {7'h00, counter_on_bit_q};
  assign stat_rd = {6'h00, irq_stat_q};
  assign mask_rd = {6'h00, irq_mask_q};
  // Unmapped addresses read as zero
  assign rd_mux = (addr == TGC_ADDR_GATE) ? gate_rd :
                  (addr == TGC_ADDR_CTRL) ? ctrl_rd :
                  (addr == TGC_ADDR_IRQ_STAT) ? stat_rd :
                  (addr == TGC_ADDR_IRQ_MASK) ? mask_rd :
                  (addr == TGC_ADDR_COUNT_LO) ? count_q[7:0] :
                  (addr == TGC_ADDR_COUNT_HI) ? count_q[15:8] : 8'h00;
  assign irq_set[TGC_IRQ_GATE] = sp_done;
  assign irq_set[TGC_IRQ_OVF] = cnt_ovf;
  // Read data only in the cycle after the strobe, zero otherwise
  assign rdata_d = rd ? rd_mux : 8'h00;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // Software-written gate fields and counter-on bit
  always_ff @(posedge clk) begin
    if (rst) begin
      gate_enable_bit_q <= TGC_RST_GATE[TGC_BIT_GE];
      gate_polarity_q <= TGC_RST_GATE[TGC_BIT_POL];
      gate_toggle_select_q <= TGC_RST_GATE[TGC_BIT_TGL];
      single_pulse_select_q <= TGC_RST_GATE[TGC_BIT_SPM];
      gate_source_select_q <= TGC_RST_GATE[TGC_BIT_SRC_HI:TGC_BIT_SRC_LO];
      counter_on_bit_q <= TGC_RST_CTRL[TGC_BIT_ON];
    end else begin
      if (wr_gate) begin
        gate_enable_bit_q <= wdata[TGC_BIT_GE];
        gate_polarity_q <= wdata[TGC_BIT_POL];
        gate_toggle_select_q <= wdata[TGC_BIT_TGL];
        single_pulse_select_q <= wdata[TGC_BIT_SPM];
        gate_source_select_q <= wdata[TGC_BIT_SRC_HI:TGC_BIT_SRC_LO];
      end
      if (wr_ctrl) begin
        counter_on_bit_q <= wdata[TGC_BIT_ON];
      end
    end
  end

  // toggle flip-flop, held clear outside toggle mode
  always_ff @(posedge clk) begin
    if (rst || !gate_toggle_select_q) begin
      toggle_ff_q <= 1'b0;
    end else if (pol_rise) begin
      toggle_ff_q <= ~toggle_ff_q;
    end
  end

  // ----------------------------------------
  // Single-pulse sequencer
  // ----------------------------------------
  // armed by software, cleared by hardware on completion
  always_ff @(posedge clk) begin
    if (rst) begin
      sp_q <= SP_IDLE;
      pulse_acquire_flag_q <= TGC_RST_GATE[TGC_BIT_ACQ];
    end else if (!single_pulse_select_q) begin
      // Mode off: sequencer idle, flag keeps software value
      sp_q <= SP_IDLE;
      if (wr_gate) begin
        pulse_acquire_flag_q <= wdata[TGC_BIT_ACQ];
      end
    end else begin
      case (sp_q)
        SP_IDLE: begin
          // A write in this cycle overrides the stored flag, so a disarm is lost only in SP_COUNT
          if (wr_gate) begin
            pulse_acquire_flag_q <= wdata[TGC_BIT_ACQ];
            if (wdata[TGC_BIT_ACQ]) begin
              sp_q <= SP_WAIT;
            end
          end else if (pulse_acquire_flag_q) begin
            sp_q <= SP_WAIT;
          end
        end
        SP_WAIT: begin
          // Waiting for the starting edge; a rising edge opens the window
          if (tgl_rise) begin
            sp_q <= SP_COUNT;
          end
          if (wr_gate && !wdata[TGC_BIT_ACQ]) begin
            pulse_acquire_flag_q <= 1'b0;
            sp_q <= SP_IDLE;
          end
        end
        SP_COUNT: begin
          // Hardware clear wins over any software write in this cycle
          if (tgl_fall) begin
            pulse_acquire_flag_q <= 1'b0;
            sp_q <= SP_IDLE;
          end
        end
        default: begin
          sp_q <= SP_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Count register pair
  // ----------------------------------------
  // Software writes take precedence over counting
  // No byte latching: a running count read as two bytes may tear
  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= TGC_RST_COUNT;
    end else if (wr_lo) begin
      count_q[7:0] <= wdata;
    end else if (wr_hi) begin
      count_q[15:8] <= wdata;
    end else if (cnt_step) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // ----------------------------------------
  // Interrupts and outputs
  // ----------------------------------------
  // Sticky status: set wins over write-one-to-clear
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_stat_q <= TGC_RST_IRQ;
      irq_mask_q <= TGC_RST_IRQ;
    end else begin
      irq_stat_q <= (irq_stat_q & ~(wr_stat ? wdata[1:0] : 2'h0)) | irq_set;
      if (wr_mask) begin
        irq_mask_q <= wdata[1:0];
      end
    end
  end

  // live gate level, independent of gate enable
  always_ff @(posedge clk) begin
    if (rst) begin
      gate_level_status_q <= 1'b0;
    end else begin
      gate_level_status_q <= gate_func;
    end
  end

  // Read data register; returns to zero so a stale byte never lingers
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // registered enable, one cycle behind the step condition without the tick term
  always_ff @(posedge clk) begin
    if (rst) begin
      count_en_q <= 1'b0;
    end else begin
      count_en_q <= counter_on_bit_q & gate_ok;
    end
  end

  // Level interrupt; registered so the pin never glitches on decode
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  assign rdata = rdata_q;
  assign count_en = count_en_q;
  assign count = count_q;
  assign irq = irq_q;
endmodule : tgc_gate_ctrl
`default_nettype wire

// >>> bench/tgc_checker.sv
// Port checker for the timer gate control block.
`timescale 1ns/1ps
`default_nettype none
module tgc_checker
  import tgc_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic [3:0] addr, // Address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  input wire logic [7:0] rdata, // Read data
  input wire logic [3:0] gate_src, // Gate sources
  input wire logic count_tick, // Tick
  input wire logic count_en, // Count enable
  input wire logic [15:0] count, // Count pair
  input wire logic irq // Interrupt
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Bus cycles on the count pair
  // ----------------------------------------
  sequence lo_rd_s;
    rd && addr == TGC_ADDR_COUNT_LO;
  endsequence
  sequence hi_rd_s;
    rd && addr == TGC_ADDR_COUNT_HI;
  endsequence
  // Read data is a one-cycle answer, zero otherwise
  rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not idle");
  unmapped_zero_a: assert property (rd && addr > TGC_ADDR_COUNT_HI |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  lo_read_a: assert property (lo_rd_s |=> rdata == $past(count[7:0]))
    else $error("count low read wrong");
  hi_read_a: assert property (hi_rd_s |=> rdata == $past(count[15:8]))
    else $error("count high read wrong");
  // Count moves only by a tick or a write, by one step at most
  count_hold_a: assert property (!count_tick && !wr |=> $stable(count))
    else $error("count moved without cause");
  count_step_a: assert property (count_tick && !wr |=>
    count == $past(count) + {15'h0000, count_en})
    else $error("count step wrong");
  lo_write_a: assert property (wr && !count_tick && addr == TGC_ADDR_COUNT_LO |=>
    count[7:0] == $past(wdata))
    else $error("count low write lost");
  hi_write_a: assert property (wr && !count_tick && addr == TGC_ADDR_COUNT_HI |=>
    count[15:8] == $past(wdata))
    else $error("count high write lost");
endmodule : tgc_checker
bind tgc_gate_ctrl tgc_checker chk_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .gate_src(gate_src), .count_tick(count_tick),
  .count_en(count_en), .count(count), .irq(irq));
`default_nettype wire

// >>> bench/tb_top.sv
// Self-checking testbench for the timer gate control block.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import tgc_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] gate_src = 4'h1;
  logic count_tick = 1'b0;
  logic [7:0] rdata;
  logic count_en;
  logic [15:0] count;
  logic irq;
  logic rd_past = 1'b0;
  logic [7:0] exp_q[$];
  logic [15:0] exp_cnt = 16'h0000;
  int seed = 32'h10a5_78a2;
  int fail_count = 0;
  int check_count = 0;
  tgc_gate_ctrl dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .gate_src(gate_src), .count_tick(count_tick),
    .count_en(count_en), .count(count), .irq(irq));
  // 25 MHz clock
  initial begin
    forever #20 clk = ~clk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  // Expectation is queued here, compared by the monitor
  task automatic rreg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rreg
  task automatic tick();
    @(posedge clk);
    count_tick <= 1'b1;
    @(posedge clk);
    count_tick <= 1'b0;
  endtask : tick
  // Unused sources get noise so a wrong select shows up
  task automatic gset(input logic lvl);
    @(posedge clk);
    gate_src <= {3'($random(seed)), lvl};
    repeat (3) @(posedge clk);
  endtask : gset
  // The interrupt pin is registered: it follows a register write one cycle later
  task automatic chk_irq(input logic want);
    @(posedge clk);
    @(negedge clk);
    check({15'h0000, irq}, {15'h0000, want});
  endtask : chk_irq
  // Read data stands only in the cycle after the strobe
  always @(posedge clk) rd_past <= rd;
  always @(negedge clk) begin
    if (rd_past === 1'b1) begin
      check({8'h00, rdata}, {8'h00, exp_q.pop_front()});
    end
  end
  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic ge;
    logic pol;
    logic lvl;
    logic st;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 6; a++) rreg(4'(a), 8'h00);
    rreg(4'hA, 8'h00);
    exp_cnt = {1'b0, 7'($random(seed)), 8'($random(seed))};
    wreg(TGC_ADDR_COUNT_LO, exp_cnt[7:0]);
    wreg(TGC_ADDR_COUNT_HI, exp_cnt[15:8]);
    wreg(TGC_ADDR_CTRL, 8'h01);
    for (int m = 0; m < 6; m++) begin
      pol = m[0];
      lvl = m[1];
      ge = (m < 4);
      st = (lvl == pol);
      wreg(TGC_ADDR_GATE, {ge, pol, 6'h00});
      gset(lvl);
      rreg(TGC_ADDR_GATE, {ge, pol, 3'h0, st, 2'h0});
      tick();
      if (!ge || st) exp_cnt++;
      rreg(TGC_ADDR_COUNT_LO, exp_cnt[7:0]);
    end
    wreg(TGC_ADDR_CTRL, 8'h00);
    tick();
    rreg(TGC_ADDR_COUNT_LO, exp_cnt[7:0]);
    wreg(TGC_ADDR_CTRL, 8'h01);
    gset(1'b0);
    wreg(TGC_ADDR_GATE, 8'hE0);
    rreg(TGC_ADDR_GATE, 8'hE0);
    gset(1'b1);
    gset(1'b0);
    rreg(TGC_ADDR_GATE, 8'hE4);
    tick();
    exp_cnt++;
    gset(1'b1);
    gset(1'b0);
    rreg(TGC_ADDR_GATE, 8'hE0);
    gset(1'b1);
    gset(1'b0);
    wreg(TGC_ADDR_GATE, 8'hC0);
    wreg(TGC_ADDR_GATE, 8'hE0);
    rreg(TGC_ADDR_GATE, 8'hE0);
    wreg(TGC_ADDR_IRQ_MASK, 8'h01);
    wreg(TGC_ADDR_GATE, 8'hD0);
    wreg(TGC_ADDR_GATE, 8'hD8);
    rreg(TGC_ADDR_GATE, 8'hD8);
    gset(1'b1);
    rreg(TGC_ADDR_GATE, 8'hDC);
    tick();
    exp_cnt++;
    gset(1'b0);
    rreg(TGC_ADDR_GATE, 8'hD0);
    rreg(TGC_ADDR_IRQ_STAT, 8'h01);
    chk_irq(1'b1);
    gset(1'b1);
    rreg(TGC_ADDR_GATE, 8'hD0);
    tick();
    gset(1'b0);
    wreg(TGC_ADDR_IRQ_MASK, 8'h00);
    chk_irq(1'b0);
    wreg(TGC_ADDR_IRQ_MASK, 8'h01);
    chk_irq(1'b1);
    wreg(TGC_ADDR_IRQ_STAT, 8'h01);
    chk_irq(1'b0);
    rreg(TGC_ADDR_IRQ_STAT, 8'h00);
    rreg(TGC_ADDR_COUNT_LO, exp_cnt[7:0]);
    rreg(TGC_ADDR_COUNT_HI, exp_cnt[15:8]);
    // Overflow wraps the count and sets the second sticky bit
    wreg(TGC_ADDR_GATE, 8'h00);
    wreg(TGC_ADDR_COUNT_LO, 8'hFF);
    wreg(TGC_ADDR_COUNT_HI, 8'hFF);
    wreg(TGC_ADDR_IRQ_MASK, 8'h02);
    tick();
    rreg(TGC_ADDR_COUNT_HI, 8'h00);
    rreg(TGC_ADDR_IRQ_STAT, 8'h02);
    chk_irq(1'b1);
    repeat (2) @(posedge clk);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
